// ==== logic/smd_fifo.sv ====
`timescale 1ns/1ns
module smd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data,
  output      logic             empty
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  // Full and empty come straight from the occupancy count
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign empty     = (count == '0);
  assign out_data  = mem[rd_ptr];

  ////////////////////////////////////////////////////////////////////////
  // Storage, no reset needed on the data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap explicitly so DEPTH need not be a power of two
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop)  rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : smd_fifo

// ==== logic/smd_pkg.sv ====
package smd_pkg;

  // Widths
  localparam int DATA_W     = 32;
  localparam int LEN_W_MAX  = 26;
  localparam int APP_WORDS  = 5;
  localparam int FIFO_DEPTH = 16;

  // Register offsets on the plain port
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_LAST = 4'h8;

  // Register field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int STAT_STOP_BIT = 0;
  localparam int STAT_ERR_BIT  = 1;

  // Values after reset
  localparam logic RUN_RESET  = 1'b0;
  localparam logic STOP_RESET = 1'b1;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // Descriptor status word layout
  localparam int STS_LEN_MSB  = 25;
  localparam int STS_EOP_BIT  = 26;
  localparam int STS_SOP_BIT  = 27;
  localparam int STS_ERR_BIT  = 28;
  localparam int STS_DONE_BIT = 31;

  // Buffer length field of the descriptor control word
  localparam int CTL_LEN_MSB = 25;

  // Byte lanes per stream beat
  localparam int BEAT_BYTES = 4;

  // Stream beat: data, count of valid bytes, packet end
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [2:0]        nbytes;
    logic              last;
  } smd_beat_t;

  // Memory write carried through the FIFO
  typedef struct packed {
    logic [31:0]       addr;
    logic [DATA_W-1:0] data;
    logic [2:0]        nbytes;
  } smd_wr_t;

  // Fetched receive descriptor
  typedef struct packed {
    logic [31:0] buf_addr;
    logic [31:0] ctrl;
  } smd_desc_t;

  // Descriptor write-back: status word, bit mask, user words
  typedef struct packed {
    logic [31:0]              word;
    logic [31:0]              mask;
    logic                     app_we;
    logic [APP_WORDS*32-1:0]  app;
  } smd_wb_t;

endpackage : smd_pkg

// ==== logic/smd_stream_to_memory_channel.sv ====
// Notes on behaviour
// - Status low field holds bytes actually stored in this descriptor's buffer.
// - Counts from start descriptor through end descriptor add up to packet length.
// - Byte count width equals the buffer-length width parameter, at most 26 bits.
// - In simple configuration the byte count field is left unwritten.
// - Bit 26 set only in the descriptor holding the packet's final part.
// - With status streams enabled, user words land in the end-of-packet descriptor.
// - Bit 27 set only in the descriptor holding the packet's first part.
// - Zero buffer length in a fetched descriptor raises the internal error, bit 28.
// - Data mover under-run or over-run also raises the internal error.
// - Internal error clears run/stop, then stopped flag rises once shut down.
// - Bit 31 set when the descriptor's transfer has finished.
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ns
module smd_stream_to_memory_channel #(
  parameter int LEN_W       = smd_pkg::LEN_W_MAX,
  parameter bit SIMPLE_MODE = 1'b0,
  parameter bit CS_ENABLE   = 1'b1,
  parameter int FIFO_DEPTH  = smd_pkg::FIFO_DEPTH
) (
  input  wire logic                                  clk,
  input  wire logic                                  rst_n,
  input  wire logic [3:0]                            reg_addr,
  input  wire logic [31:0]                           reg_wdata,
  input  wire logic                                  reg_wr,
  input  wire logic                                  reg_rd,
  output      logic [31:0]                           reg_rdata,
  input  wire logic                                  desc_valid,
  output      logic                                  desc_ready,
  input  wire smd_pkg::smd_desc_t                    desc,
  input  wire logic                                  s_valid,
  output      logic                                  s_ready,
  input  wire smd_pkg::smd_beat_t                    s_beat,
  input  wire logic                                  app_valid,
  output      logic                                  app_ready,
  input  wire logic [smd_pkg::APP_WORDS*32-1:0]      app_data,
  output      logic                                  mem_valid,
  input  wire logic                                  mem_ready,
  output      smd_pkg::smd_wr_t                      mem_wr,
  input  wire logic                                  dm_underrun,
  input  wire logic                                  dm_overrun,
  output      logic                                  wb_valid,
  input  wire logic                                  wb_ready,
  output      smd_pkg::smd_wb_t                      wb
);

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_FETCH = 5'b00010,
    ST_MOVE  = 5'b00100,
    ST_DRAIN = 5'b01000,
    ST_WBACK = 5'b10000
  } smd_state_t;

  ////////////////////////////////////////////////////////////////////////
  // Status word assembly, shared by write-back and the readable copy
  function automatic logic [31:0] smd_status(input logic [LEN_W-1:0] cnt,
                                             input logic eop,
                                             input logic sop,
                                             input logic err);
    logic [31:0] w;
    w = smd_pkg::WORD_RESET;
    w[LEN_W-1:0] = cnt;
    w[smd_pkg::STS_EOP_BIT]  = eop;
    w[smd_pkg::STS_SOP_BIT]  = sop;
    w[smd_pkg::STS_ERR_BIT]  = err;
    w[smd_pkg::STS_DONE_BIT] = 1'b1;
    return w;
  endfunction : smd_status

  ////////////////////////////////////////////////////////////////////////
  // State and datapath registers
  smd_state_t        state;
  smd_state_t        next_state;
  logic              run;
  logic              stopped;
  logic              err_sticky;
  logic [31:0]       last_status;
  logic [LEN_W-1:0]  buf_len;
  logic [LEN_W-1:0]  cnt;
  logic [31:0]       wr_addr;
  logic              sop_q;
  logic              eop_q;
  logic              cur_err;
  logic              in_packet;
  logic              app_held;
  logic [smd_pkg::APP_WORDS*32-1:0] app_q;

  // FIFO wiring
  logic              fifo_in_ready;
  logic              fifo_empty;
  smd_pkg::smd_wr_t  fifo_in;

  ////////////////////////////////////////////////////////////////////////
  // Handshake decode
  wire               in_fetch   = (state == ST_FETCH);
  wire               in_move    = (state == ST_MOVE);
  wire               in_drain   = (state == ST_DRAIN);
  wire               in_wback   = (state == ST_WBACK);
  wire               busy       = in_move || in_drain;
  wire               fetch_take = in_fetch && desc_valid && run;
  wire [LEN_W-1:0]   desc_len   = desc.ctrl[LEN_W-1:0];
  wire               len_zero   = (desc_len == '0);
  wire               s_take     = s_valid && s_ready;
  wire [LEN_W:0]     sum_next   = {1'b0, cnt} + {{(LEN_W-2){1'b0}}, s_beat.nbytes};
  wire               beat_over  = s_take && (sum_next > {1'b0, buf_len});
  wire               buf_full   = s_take && !beat_over && (sum_next == {1'b0, buf_len});
  wire               dm_err     = busy && (dm_underrun || dm_overrun);
  wire               err_event  = (fetch_take && len_zero) || dm_err || beat_over;
  wire               app_wait   = CS_ENABLE && eop_q && !app_held;
  wire               drained    = in_drain && fifo_empty && !app_wait;
  wire               wb_take    = wb_valid && wb_ready;

  assign desc_ready = in_fetch && run;
  assign s_ready    = in_move && fifo_in_ready;
  assign app_ready  = !app_held;
  assign wb_valid   = in_wback;

  // Over-length beats are swallowed, never written past the buffer end
  assign fifo_in.addr   = wr_addr;
  assign fifo_in.data   = s_beat.data;
  assign fifo_in.nbytes = s_beat.nbytes;

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (run) next_state = ST_FETCH;
      end
      ST_FETCH: begin
        if (!run) next_state = ST_IDLE;
        else if (desc_valid) next_state = len_zero ? ST_DRAIN : ST_MOVE;
      end
      ST_MOVE: begin
        if (dm_err || beat_over) next_state = ST_DRAIN;
        else if (s_take && (s_beat.last || buf_full)) next_state = ST_DRAIN;
      end
      ST_DRAIN: begin
        if (drained) next_state = ST_WBACK;
      end
      ST_WBACK: begin
        if (wb_ready) next_state = (cur_err || !run) ? ST_IDLE : ST_FETCH;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) state <= ST_IDLE;
    else        state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-descriptor capture: length, address and start flag at fetch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_len <= '0;
      wr_addr <= smd_pkg::WORD_RESET;
      sop_q   <= 1'b0;
    end else if (fetch_take) begin
      buf_len <= desc_len;
      wr_addr <= desc.buf_addr;
      sop_q   <= !in_packet;
    end else if (s_take && !beat_over) begin
      wr_addr <= wr_addr + 32'h0000_0004;
    end
  end

  // Byte count restarts per descriptor, so chained counts sum to the packet
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)                    cnt <= '0;
    else if (fetch_take)           cnt <= '0;
    else if (s_take && !beat_over) cnt <= sum_next[LEN_W-1:0];
  end

  // End flag only for the buffer that takes the last beat
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)                              eop_q <= 1'b0;
    else if (fetch_take)                     eop_q <= 1'b0;
    else if (s_take && !beat_over)           eop_q <= s_beat.last;
  end

  // Error for the descriptor now in flight
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)          cur_err <= 1'b0;
    else if (err_event)  cur_err <= 1'b1;
    else if (fetch_take) cur_err <= 1'b0;
  end

  // Packet tracking across descriptors; an error abandons the packet
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)       in_packet <= 1'b0;
    else if (wb_take) in_packet <= !eop_q && !cur_err;
  end

  ////////////////////////////////////////////////////////////////////////
  // User words from the status stream, held until the end descriptor goes out
  // Words of a packet cut by an error are released at its error write-back,
  // so they can never be attached to the next packet
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      app_held <= 1'b0;
      app_q    <= '0;
    end else if (app_valid && app_ready) begin
      app_held <= 1'b1;
      app_q    <= app_data;
    end else if (wb_take && (eop_q || cur_err)) begin
      app_held <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write-back image, built once as the drain finishes and held until taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb <= '0;
    end else if (drained) begin
      wb.word   <= smd_status(cnt, eop_q, sop_q, cur_err);
      wb.mask   <= SIMPLE_MODE ? 32'hFC00_0000 : 32'hFFFF_FFFF;
      wb.app_we <= CS_ENABLE;
      wb.app    <= eop_q ? app_q : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Software registers; hardware actions win over a software write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run <= smd_pkg::RUN_RESET;
    end else if (err_event) begin
      run <= 1'b0;
    end else if (reg_wr && reg_addr == smd_pkg::REG_CTRL) begin
      run <= reg_wdata[smd_pkg::CTRL_RUN_BIT];
    end
  end

  // Stopped only once idle, so the FIFO and write-back are already done
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) stopped <= smd_pkg::STOP_RESET;
    else        stopped <= (state == ST_IDLE) && !run;
  end

  // Sticky error, write one to clear; a new error wins over the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_sticky <= 1'b0;
    end else if (err_event) begin
      err_sticky <= 1'b1;
    end else if (reg_wr && reg_addr == smd_pkg::REG_STAT && reg_wdata[smd_pkg::STAT_ERR_BIT]) begin
      err_sticky <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)       last_status <= smd_pkg::WORD_RESET;
    else if (wb_take) last_status <= wb.word;
  end

  // Read data stands one cycle after the strobe; unmapped reads give zero
  wire [31:0] rd_ctrl = {31'h0000_0000, run};
  wire [31:0] rd_stat = {30'h0000_0000, err_sticky, stopped};
  wire [31:0] rd_mux  = (reg_addr == smd_pkg::REG_CTRL) ? rd_ctrl :
                        (reg_addr == smd_pkg::REG_STAT) ? rd_stat :
                        (reg_addr == smd_pkg::REG_LAST) ? last_status : smd_pkg::WORD_RESET;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)      reg_rdata <= smd_pkg::WORD_RESET;
    else if (reg_rd) reg_rdata <= rd_mux;
    else             reg_rdata <= smd_pkg::WORD_RESET;
  end

  ////////////////////////////////////////////////////////////////////////
  // Data path buffer toward memory; its fullness stalls the stream
  smd_fifo #(
    .WIDTH ($bits(smd_pkg::smd_wr_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (s_take && !beat_over),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (mem_valid),
    .out_ready (mem_ready),
    .out_data  (mem_wr),
    .empty     (fifo_empty)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  zero_len_err_a: assert property (fetch_take && len_zero |=> cur_err && in_drain ##1 wb_valid)
    else $error("zero length descriptor did not raise error");

  dm_err_flag_a: assert property (busy && dm_overrun |=> cur_err && !run)
    else $error("data mover fault not reported");

  halt_run_a: assert property (err_event |=> !run)
    else $error("run bit not cleared on internal error");

  stop_after_idle_a: assert property (stopped |-> $past(state == ST_IDLE) && $past(!run))
    else $error("stopped flag raised while engine active");

  done_and_flags_a: assert property (wb_valid |-> wb.word[smd_pkg::STS_DONE_BIT]
                                     && wb.word[smd_pkg::STS_EOP_BIT] == eop_q
                                     && wb.word[smd_pkg::STS_SOP_BIT] == sop_q)
    else $error("status flags wrong at write-back");

  count_field_a: assert property (wb_valid |-> wb.word[LEN_W-1:0] == cnt && cnt <= buf_len)
    else $error("transferred count wrong");

  simple_mask_a: assert property (wb_valid |-> (wb.mask[smd_pkg::STS_LEN_MSB:0] == '0) == SIMPLE_MODE)
    else $error("count field mask wrong for configuration");

  wb_stable_a: assert property (wb_valid && !wb_ready |=> wb_valid && $stable(wb))
    else $error("write-back changed before taken");

  app_eop_a: assert property (wb_valid && eop_q && CS_ENABLE |-> wb.app == app_q)
    else $error("user words not in end descriptor");

  next_sop_a: assert property (wb_take && eop_q |=> !in_packet)
    else $error("packet end did not restart counting");

  app_release_a: assert property (wb_take && cur_err && app_held |=> !app_held)
    else $error("user words of abandoned packet kept");

  wb_after_data_a: assert property (wb_valid |-> fifo_empty)
    else $error("write-back issued before data reached memory");

  halt_idle_a: assert property (wb_take && cur_err |=> state == ST_IDLE)
    else $error("engine kept running after internal error");

  drop_over_a: assert property (beat_over |=> $stable(cnt))
    else $error("dropped beat counted as stored");

endmodule : smd_stream_to_memory_channel

// ==== verif/smd_partner.sv ====
`timescale 1ns/1ns
module smd_partner (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               stall,
  input  wire logic               post,
  input  wire logic [25:0]        len,
  output      logic               desc_valid,
  input  wire logic               desc_ready,
  output      smd_pkg::smd_desc_t desc,
  input  wire logic               mem_valid,
  output      logic               mem_ready,
  input  wire smd_pkg::smd_wr_t   mem_wr,
  input  wire logic               wb_valid,
  output      logic               wb_ready,
  input  wire smd_pkg::smd_wb_t   wb,
  output      smd_pkg::smd_wb_t   wb_last,
  output      int                 wb_cnt,
  output      smd_pkg::smd_wr_t   mem_last,
  output      int                 mem_bytes
);
  logic [31:0] next_addr;
  logic        tick;

  // Memory takes data unless stalled; status write-back is slow on purpose
  assign mem_ready = !stall;
  assign wb_ready  = tick;

  ////////////////////////////////////////////////////////////////////////
  // Descriptor offer held until taken; idle bus toggles so stale values show
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      desc_valid <= 1'b0;
      desc       <= '0;
      next_addr  <= 32'h0000_1000;
    end else if (post) begin
      desc_valid <= 1'b1;
      desc       <= {next_addr, 6'h00, len};
      next_addr  <= next_addr + 32'h0000_1000;
    end else begin
      if (desc_ready) desc_valid <= 1'b0;
      if (desc_ready || !desc_valid) desc <= ~desc;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Memory store: counts stored bytes and keeps the last status word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick      <= 1'b0;
      wb_last   <= '0;
      wb_cnt    <= 0;
      mem_bytes <= 0;
      mem_last  <= '0;
    end else begin
      tick <= !tick;
      if (mem_valid && mem_ready) mem_bytes <= mem_bytes + int'(mem_wr.nbytes);
      if (mem_valid && mem_ready) mem_last <= mem_wr;
      if (wb_valid && wb_ready) begin
        wb_last <= wb;
        wb_cnt  <= wb_cnt + 1;
      end
    end
  end
endmodule : smd_partner

// ==== verif/smd_stream_to_memory_channel_tb.sv ====
`timescale 1ns/1ns
module smd_stream_to_memory_channel_tb;
  logic clk, rst_n, reg_wr, reg_rd, desc_valid, desc_ready, s_valid, s_ready;
  logic app_valid, app_ready, mem_valid, mem_ready, dm_underrun, dm_overrun;
  logic wb_valid, wb_ready, stall, post;
  logic [3:0]                      reg_addr;
  logic [31:0]                     reg_wdata, reg_rdata;
  logic [25:0]                     len;
  logic [smd_pkg::APP_WORDS*32-1:0] app_data;
  smd_pkg::smd_desc_t              desc;
  smd_pkg::smd_beat_t              s_beat;
  smd_pkg::smd_wr_t                mem_wr, mem_last;
  smd_pkg::smd_wb_t                wb, wb_last;
  int                              wb_cnt, mem_bytes, bad_count, n_tests, c, i;

  smd_stream_to_memory_channel DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .desc_valid(desc_valid), .desc_ready(desc_ready), .desc(desc),
    .s_valid(s_valid), .s_ready(s_ready), .s_beat(s_beat), .app_valid(app_valid), .app_ready(app_ready),
    .app_data(app_data), .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_wr(mem_wr),
    .dm_underrun(dm_underrun), .dm_overrun(dm_overrun), .wb_valid(wb_valid), .wb_ready(wb_ready), .wb(wb));

  smd_partner far_end (.clk(clk), .rst_n(rst_n), .stall(stall), .post(post), .len(len),
    .desc_valid(desc_valid), .desc_ready(desc_ready), .desc(desc), .mem_valid(mem_valid),
    .mem_ready(mem_ready), .mem_wr(mem_wr), .wb_valid(wb_valid), .wb_ready(wb_ready), .wb(wb),
    .wb_last(wb_last), .wb_cnt(wb_cnt), .mem_last(mem_last), .mem_bytes(mem_bytes));

  // 25 MHz clock
  always #20 clk = !clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    if (bad_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : check32

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check32(reg_rdata, exp);
  endtask : reg_read

  task automatic post_desc(input logic [25:0] l);
    @(posedge clk);
    post <= 1'b1;
    len  <= l;
    @(posedge clk);
    post <= 1'b0;
  endtask : post_desc

  // Beat held until ready seen before an edge; a bound that runs out is a mismatch
  task automatic send_beat(input logic [31:0] d, input logic [2:0] n, input logic l);
    int k;
    k = 0;
    @(posedge clk);
    s_valid <= 1'b1;
    s_beat  <= '{data: d, nbytes: n, last: l};
    do begin
      @(negedge clk);
      k++;
    end while (!s_ready && k < 200);
    check32(32'(s_ready), 32'h0000_0001);
    @(posedge clk);
    s_valid <= 1'b0;
  endtask : send_beat

  task automatic send_app(input logic [31:0] w);
    int k;
    k = 0;
    @(posedge clk);
    app_valid <= 1'b1;
    app_data  <= {5{w}};
    do begin
      @(negedge clk);
      k++;
    end while (!app_ready && k < 20);
    check32(32'(app_ready), 32'h0000_0001);
    @(posedge clk);
    app_valid <= 1'b0;
  endtask : send_app

  task automatic wait_wb(input int n);
    int k;
    k = 0;
    while (wb_cnt < n && k < 500) begin
      @(posedge clk);
      k++;
    end
    check32(32'(wb_cnt), 32'(n));
  endtask : wait_wb

  ////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 0; rst_n = 0; reg_wr = 0; reg_rd = 0; reg_addr = '0; reg_wdata = '0;
    s_valid = 0; s_beat = '0; app_valid = 0; app_data = '0; dm_underrun = 0; dm_overrun = 0;
    stall = 0; post = 0; len = '0; bad_count = 0; n_tests = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    reg_read(smd_pkg::REG_STAT, 32'h0000_0001);
    reg_read(smd_pkg::REG_CTRL, 32'h0000_0000);
    reg_read(4'hC, 32'h0000_0000);
    reg_write(smd_pkg::REG_CTRL, 32'h0000_0001);
    reg_read(smd_pkg::REG_STAT, 32'h0000_0000);
    // Single-descriptor packet
    post_desc(26'd8);
    send_app(32'hA5A5_0001);
    send_beat(32'h1111_2222, 3'd4, 1'b0);
    send_beat(32'h3333_4444, 3'd4, 1'b1);
    wait_wb(1);
    check32(wb_last.word, 32'h8C00_0008);
    check32(wb_last.mask, 32'hFFFF_FFFF);
    check32(wb_last.app[31:0], 32'hA5A5_0001);
    check32(wb_last.app[159:128], 32'hA5A5_0001);
    check32(mem_last.addr, 32'h0000_1004);
    check32(mem_last.data, 32'h3333_4444);
    check32(32'(wb_last.app_we), 32'h0000_0001);
    // Packet spread over two descriptors, first one filled exactly
    post_desc(26'd8);
    send_beat(32'h0000_0001, 3'd4, 1'b0);
    send_beat(32'h0000_0002, 3'd4, 1'b0);
    wait_wb(2);
    check32(wb_last.word, 32'h8800_0008);
    check32(wb_last.app[31:0], 32'h0000_0000);
    post_desc(26'd16);
    send_app(32'hA5A5_0002);
    send_beat(32'h0000_0003, 3'd4, 1'b0);
    send_beat(32'h0000_0004, 3'd2, 1'b1);
    wait_wb(3);
    check32(wb_last.word, 32'h8400_0006);
    check32(32'(mem_bytes), 32'h0000_0016);
    // Memory stalls until the FIFO refuses, then drains
    stall <= 1'b1;
    post_desc(26'd80);
    send_app(32'hA5A5_0003);
    fork
      for (i = 0; i < 20; i++) send_beat(32'(i), 3'd4, i == 19);
      begin
        repeat (60) @(posedge clk);
        check32(32'(s_ready), 32'h0000_0000);
        check32(32'(mem_bytes), 32'h0000_0016);
        stall <= 1'b0;
      end
    join
    wait_wb(4);
    check32(wb_last.word, 32'h8C00_0050);
    check32(32'(mem_bytes), 32'h0000_0066);
    reg_read(smd_pkg::REG_LAST, 32'h8C00_0050);
    // Over-length beat, then under-run and over-run pulses
    for (c = 0; c < 3; c++) begin
      post_desc(26'd6);
      send_app(32'hA5A5_0004);
      send_beat(32'h0000_0005, 3'd4, 1'b0);
      if (c == 0) begin
        send_beat(32'h0000_0006, 3'd4, 1'b1);
      end else begin
        @(posedge clk);
        dm_underrun <= (c == 1);
        dm_overrun  <= (c == 2);
        @(posedge clk);
        dm_underrun <= 1'b0;
        dm_overrun  <= 1'b0;
      end
      wait_wb(5 + c);
      check32(wb_last.word & 32'h1000_0000, 32'h1000_0000);
      repeat (4) @(posedge clk);
      reg_read(smd_pkg::REG_CTRL, 32'h0000_0000);
      reg_read(smd_pkg::REG_STAT, 32'h0000_0003);
      reg_write(smd_pkg::REG_STAT, 32'h0000_0002);
      reg_read(smd_pkg::REG_STAT, 32'h0000_0001);
      reg_write(smd_pkg::REG_CTRL, 32'h0000_0001);
    end
    // Zero buffer length
    post_desc(26'd0);
    wait_wb(8);
    check32(wb_last.word & 32'h13FF_FFFF, 32'h1000_0000);
    repeat (4) @(posedge clk);
    reg_read(smd_pkg::REG_CTRL, 32'h0000_0000);
    reg_write(smd_pkg::REG_STAT, 32'h0000_0002);
    reg_write(smd_pkg::REG_CTRL, 32'h0000_0001);
    // First descriptor after a restart starts a packet
    send_app(32'hA5A5_0005);
    post_desc(26'd4);
    send_beat(32'h0000_0008, 3'd4, 1'b1);
    wait_wb(9);
    check32(wb_last.word, 32'h8C00_0004);
    check32(wb_last.app[31:0], 32'hA5A5_0005);
    finish_test();
  end
endmodule : smd_stream_to_memory_channel_tb
